// ===== logic/rac_params.svh
`ifndef RAC_PARAMS_SVH
`define RAC_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define RAC_ADDR_W 4
`define RAC_OWN_ADDR_OFS 4'h0
`define RAC_RATE_OFS 4'h4
`define RAC_SCLDIV_OFS 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RAC_SLV_HI 7
`define RAC_SLV_LO 1
`define RAC_RATE_MULTIPLIER_FIELD_HI 7
`define RAC_RATE_MULTIPLIER_FIELD_LO 6
`define RAC_IDX_HI 5
`define RAC_IDX_LO 0

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define RAC_OWN_ADDR_RST 7'h00
`define RAC_RATE_RST 8'h00
`define RAC_RESP_OKAY 2'h0
`define RAC_RESP_SLVERR 2'h2

`endif

// ===== logic/rac_pkg.sv
`default_nettype none
package rac_pkg;
	// hold timer states
	typedef enum logic {HOLD_IDLE, HOLD_RUN} rac_hold_st_t;
	// multiplier codes
	typedef enum logic [1:0] {MUL_X1, MUL_X2, MUL_X4, MUL_RSVD} rac_mul_t;
	// which register an address selects
	typedef enum logic [1:0] {SEL_OWN, SEL_RATE, SEL_SCLDIV, SEL_NONE} rac_sel_t;
endpackage
`default_nettype wire

// ===== logic/rac_rate_lut.sv
`timescale 1ns/1ps
`default_nettype none
module rac_rate_lut (
	input wire logic [5:0] idx, // rate index
	output logic [11:0] scl_div, // base clock divider
	output logic [9:0] sda_hold, // base data hold value
	output logic [10:0] start_hold, // base start hold value
	output logic [10:0] stop_hold // base stop hold value
);
	// ----------------------------------------------------------------
	// table rows
	// ----------------------------------------------------------------
	function automatic logic [43:0] row(input int d, input int s, input int a, input int p);
		row = {12'(d), 10'(s), 11'(a), 11'(p)};
	endfunction

	logic [43:0] r;

	// fixed index to divider and hold mapping, no state
	always_comb
	begin
		case (idx)
			6'h00: r = row(20, 7, 6, 11);
			6'h01: r = row(22, 7, 7, 12);
			6'h02: r = row(24, 8, 8, 13);
			6'h03: r = row(26, 8, 9, 14);
			6'h04: r = row(28, 9, 10, 15);
			6'h05: r = row(30, 9, 11, 16);
			6'h06: r = row(34, 10, 13, 18);
			6'h07: r = row(40, 10, 16, 21);
			6'h08: r = row(28, 7, 10, 15);
			6'h09: r = row(32, 7, 12, 17);
			6'h0A: r = row(36, 9, 14, 19);
			6'h0B: r = row(40, 9, 16, 21);
			6'h0C: r = row(44, 11, 18, 23);
			6'h0D: r = row(48, 11, 20, 25);
			6'h0E: r = row(56, 13, 24, 29);
			6'h0F: r = row(68, 13, 30, 35);
			6'h10: r = row(48, 9, 18, 25);
			6'h11: r = row(56, 9, 22, 29);
			6'h12: r = row(64, 13, 26, 33);
			6'h13: r = row(72, 13, 30, 37);
			6'h14: r = row(80, 17, 34, 41);
			6'h15: r = row(88, 17, 38, 45);
			6'h16: r = row(104, 21, 46, 53);
			6'h17: r = row(128, 21, 58, 65);
			6'h18: r = row(80, 9, 38, 41);
			6'h19: r = row(96, 9, 46, 49);
			6'h1A: r = row(112, 17, 54, 57);
			6'h1B: r = row(128, 17, 62, 65);
			6'h1C: r = row(144, 25, 70, 73);
			6'h1D: r = row(160, 25, 78, 81);
			6'h1E: r = row(192, 33, 94, 97);
			6'h1F: r = row(240, 33, 118, 121);
			6'h20: r = row(160, 17, 78, 81);
			6'h21: r = row(192, 17, 94, 97);
			6'h22: r = row(224, 33, 110, 113);
			6'h23: r = row(256, 33, 126, 129);
			6'h24: r = row(288, 49, 142, 145);
			6'h25: r = row(320, 49, 158, 161);
			6'h26: r = row(384, 65, 190, 193);
			6'h27: r = row(480, 65, 238, 241);
			6'h28: r = row(320, 33, 158, 161);
			6'h29: r = row(384, 33, 190, 193);
			6'h2A: r = row(448, 65, 222, 225);
			6'h2B: r = row(512, 65, 254, 257);
			6'h2C: r = row(576, 97, 286, 289);
			6'h2D: r = row(640, 97, 318, 321);
			6'h2E: r = row(768, 129, 382, 385);
			6'h2F: r = row(960, 129, 478, 481);
			6'h30: r = row(640, 65, 318, 321);
			6'h31: r = row(768, 65, 382, 385);
			6'h32: r = row(896, 129, 446, 449);
			6'h33: r = row(1024, 129, 510, 513);
			6'h34: r = row(1152, 193, 574, 577);
			6'h35: r = row(1280, 193, 638, 641);
			6'h36: r = row(1536, 257, 766, 769);
			6'h37: r = row(1920, 257, 958, 961);
			6'h38: r = row(1280, 129, 638, 641);
			6'h39: r = row(1536, 129, 766, 769);
			6'h3A: r = row(1792, 257, 894, 897);
			6'h3B: r = row(2048, 257, 1022, 1025);
			6'h3C: r = row(2304, 385, 1150, 1153);
			6'h3D: r = row(2560, 385, 1278, 1281);
			6'h3E: r = row(3072, 513, 1534, 1537);
			6'h3F: r = row(3840, 513, 1918, 1921);
			default: r = row(20, 7, 6, 11);
		endcase
	end

	// unpack the selected row
	assign scl_div = r[43:32];
	assign sda_hold = r[31:22];
	assign start_hold = r[21:11];
	assign stop_hold = r[10:0];
endmodule // rac_rate_lut
`default_nettype wire

// ===== logic/rac_top.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rac_params.svh"
module rac_top
	import rac_pkg::*;
#(
	parameter int CNT_W = 14
)(
	input wire logic MCLK, // 125 MHz bus clock
	input wire logic RST_B, // async reset, active low
	input wire logic [`RAC_ADDR_W-1:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [`RAC_ADDR_W-1:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	input wire logic DATA_HOLD_GO, // serial clock fell, start data hold
	input wire logic START_HOLD_GO, // data fell with clock high
	input wire logic STOP_HOLD_GO, // serial clock rose for stop
	output logic [6:0] OWN_ADDR, // own slave address
	output logic [CNT_W-1:0] SCL_DIVIDER, // bus cycles per serial bit
	output logic [CNT_W-1:0] SDA_HOLD_CNT, // scaled data hold
	output logic [CNT_W-1:0] START_HOLD_CNT, // scaled start hold
	output logic [CNT_W-1:0] STOP_HOLD_CNT, // scaled stop hold
	output logic BIT_TICK, // one pulse per serial bit period
	output logic HOLD_BUSY, // a hold delay is running
	output logic HOLD_DONE // pulse: hold delay elapsed
);
	// ----------------------------------------------------------------
	// checks and helpers
	// ----------------------------------------------------------------
	// largest scaled value is 3840 x 4, needs 14 bits
	if (CNT_W < 14)
	begin : g_bad_width
		$error("rac_top: CNT_W must be at least 14");
	end

	// reserved code falls back to x1 so the divider never stalls
	function automatic logic [CNT_W-1:0] scale(input logic [11:0] v, input rac_mul_t m);
		case (m)
			MUL_X2: scale = CNT_W'({v, 1'b0});
			MUL_X4: scale = CNT_W'({v, 2'b00});
			default: scale = CNT_W'(v);
		endcase
	endfunction

	function automatic rac_sel_t reg_sel(input logic [`RAC_ADDR_W-1:0] a);
		case (a)
			`RAC_OWN_ADDR_OFS: reg_sel = SEL_OWN;
			`RAC_RATE_OFS: reg_sel = SEL_RATE;
			`RAC_SCLDIV_OFS: reg_sel = SEL_SCLDIV;
			default: reg_sel = SEL_NONE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state declarations
	// ----------------------------------------------------------------
	logic aw_have, next_aw_have, w_have, next_w_have;
	logic [`RAC_ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic w_lane0, next_w_lane0;
	logic next_awready, next_wready, next_bvalid, wr_en;
	logic [1:0] next_bresp;
	logic next_arready, next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [6:0] own_addr, next_own_addr;
	logic [7:0] rate_reg, next_rate_reg;
	logic rate_wr;
	logic [11:0] lut_div;
	logic [9:0] lut_sda;
	logic [10:0] lut_start, lut_stop;
	logic [CNT_W-1:0] next_scl_div, next_sda, next_start, next_stop;
	logic [CNT_W-1:0] tick_cnt, next_tick_cnt;
	logic next_tick;
	rac_hold_st_t hold_st, next_hold_st;
	logic [CNT_W-1:0] hold_cnt, next_hold_cnt;
	logic next_hold_done;
	rac_mul_t mul;

	assign mul = rac_mul_t'(rate_reg[`RAC_RATE_MULTIPLIER_FIELD_HI:`RAC_RATE_MULTIPLIER_FIELD_LO]);

	// ----------------------------------------------------------------
	// bus write channel
	// ----------------------------------------------------------------
	// address and data taken in either order; commit once both held
	always_comb
	begin
		next_aw_have = aw_have;
		next_aw_addr = aw_addr;
		next_w_have = w_have;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = S_AXI_BVALID;
		next_bresp = S_AXI_BRESP;
		wr_en = 1'b0;
		if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			next_aw_have = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			next_w_have = 1'b1;
			next_w_data = S_AXI_WDATA;
			next_w_lane0 = S_AXI_WSTRB[0];
		end
		if (S_AXI_BVALID && S_AXI_BREADY)
			next_bvalid = 1'b0;
		if (aw_have && w_have && !S_AXI_BVALID)
		begin
			wr_en = 1'b1;
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
			next_bvalid = 1'b1;
			// the divider readback is status only, so writing it is an error
			if (reg_sel(aw_addr) == SEL_OWN || reg_sel(aw_addr) == SEL_RATE)
				next_bresp = `RAC_RESP_OKAY;
			else
				next_bresp = `RAC_RESP_SLVERR;
		end
		next_awready = !next_aw_have && !next_bvalid;
		next_wready = !next_w_have && !next_bvalid;
	end

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			aw_have <= 1'b0;
			aw_addr <= '0;
			w_have <= 1'b0;
			w_data <= '0;
			w_lane0 <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RAC_RESP_OKAY;
		end
		else
		begin
			aw_have <= next_aw_have;
			aw_addr <= next_aw_addr;
			w_have <= next_w_have;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY <= next_wready;
			S_AXI_BVALID <= next_bvalid;
			S_AXI_BRESP <= next_bresp;
		end
	end

	// ----------------------------------------------------------------
	// bus read channel
	// ----------------------------------------------------------------
	// one read at a time; data captured at the address handshake
	always_comb
	begin
		// arready rises one edge after reset release, and stays up while no read is pending
		next_arready = S_AXI_ARREADY || !S_AXI_RVALID;
		next_rvalid = S_AXI_RVALID;
		next_rdata = S_AXI_RDATA;
		next_rresp = S_AXI_RRESP;
		if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `RAC_RESP_OKAY;
			case (reg_sel(S_AXI_ARADDR))
				SEL_OWN: next_rdata = {24'h00_0000, own_addr, 1'b0};
				SEL_RATE: next_rdata = {24'h00_0000, rate_reg};
				SEL_SCLDIV: next_rdata = 32'(SCL_DIVIDER);
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = `RAC_RESP_SLVERR;
				end
			endcase
		end
		else if (S_AXI_RVALID && S_AXI_RREADY)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `RAC_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= next_arready;
			S_AXI_RVALID <= next_rvalid;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers and derived counts
	// ----------------------------------------------------------------
	rac_rate_lut u_lut (
		.idx(rate_reg[`RAC_IDX_HI:`RAC_IDX_LO]),
		.scl_div(lut_div),
		.sda_hold(lut_sda),
		.start_hold(lut_start),
		.stop_hold(lut_stop)
	);

	// only byte lane 0 carries register bits
	always_comb
	begin
		next_own_addr = own_addr;
		next_rate_reg = rate_reg;
		rate_wr = 1'b0;
		if (wr_en && w_lane0 && reg_sel(aw_addr) == SEL_OWN)
			next_own_addr = w_data[`RAC_SLV_HI:`RAC_SLV_LO];
		if (wr_en && w_lane0 && reg_sel(aw_addr) == SEL_RATE)
		begin
			next_rate_reg = w_data[7:0];
			rate_wr = 1'b1;
		end
		next_scl_div = scale(lut_div, mul);
		next_sda = scale(12'(lut_sda), mul);
		next_start = scale(12'(lut_start), mul);
		next_stop = scale(12'(lut_stop), mul);
	end

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			own_addr <= `RAC_OWN_ADDR_RST;
			rate_reg <= `RAC_RATE_RST;
			OWN_ADDR <= `RAC_OWN_ADDR_RST;
			SCL_DIVIDER <= '0;
			SDA_HOLD_CNT <= '0;
			START_HOLD_CNT <= '0;
			STOP_HOLD_CNT <= '0;
		end
		else
		begin
			own_addr <= next_own_addr;
			rate_reg <= next_rate_reg;
			OWN_ADDR <= next_own_addr;
			SCL_DIVIDER <= next_scl_div;
			SDA_HOLD_CNT <= next_sda;
			START_HOLD_CNT <= next_start;
			STOP_HOLD_CNT <= next_stop;
		end
	end

	// ----------------------------------------------------------------
	// bit rate divider and hold timer
	// ----------------------------------------------------------------
	// a rate write restarts the bit period so no stale long count lingers
	always_comb
	begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + CNT_W'(1);
		if (rate_wr || SCL_DIVIDER == '0)
			next_tick_cnt = '0;
		else if (tick_cnt >= SCL_DIVIDER - CNT_W'(1))
		begin
			next_tick_cnt = '0;
			next_tick = 1'b1;
		end
		// a new request restarts the delay; start wins, then stop, then data
		next_hold_st = hold_st;
		next_hold_cnt = hold_cnt;
		next_hold_done = 1'b0;
		case (hold_st)
			HOLD_IDLE: ;
			HOLD_RUN:
			begin
				next_hold_cnt = hold_cnt - CNT_W'(1);
				if (hold_cnt <= CNT_W'(1))
				begin
					next_hold_st = HOLD_IDLE;
					next_hold_cnt = '0;
					next_hold_done = 1'b1;
				end
			end
			default: next_hold_st = HOLD_IDLE;
		endcase
		if (START_HOLD_GO)
		begin
			next_hold_st = HOLD_RUN;
			next_hold_cnt = START_HOLD_CNT;
			next_hold_done = 1'b0;
		end
		else if (STOP_HOLD_GO)
		begin
			next_hold_st = HOLD_RUN;
			next_hold_cnt = STOP_HOLD_CNT;
			next_hold_done = 1'b0;
		end
		else if (DATA_HOLD_GO)
		begin
			next_hold_st = HOLD_RUN;
			next_hold_cnt = SDA_HOLD_CNT;
			next_hold_done = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			tick_cnt <= '0;
			BIT_TICK <= 1'b0;
			hold_st <= HOLD_IDLE;
			hold_cnt <= '0;
			HOLD_BUSY <= 1'b0;
			HOLD_DONE <= 1'b0;
		end
		else
		begin
			tick_cnt <= next_tick_cnt;
			BIT_TICK <= next_tick;
			hold_st <= next_hold_st;
			hold_cnt <= next_hold_cnt;
			HOLD_BUSY <= (next_hold_st == HOLD_RUN);
			HOLD_DONE <= next_hold_done;
		end
	end
endmodule // rac_top
`default_nettype wire

// ===== tb/rac_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far side sequencer: one command gives one wire event pulse
// ----------------------------------------------------------------
module rac_far_end (
	input wire logic clk, // bus clock
	input wire logic rst_b, // reset, low
	input wire logic fire, // issue one event
	input wire logic [1:0] kind, // 0 data, 1 start, 2 stop
	output logic data_go, // clock fell
	output logic start_go, // data fell, clock high
	output logic stop_go // clock rose for stop
);
	// pulses, not levels: the wire events are instants
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			data_go <= 1'b0;
			start_go <= 1'b0;
			stop_go <= 1'b0;
		end
		else
		begin
			data_go <= fire && kind == 2'h0;
			start_go <= fire && kind == 2'h1;
			stop_go <= fire && kind == 2'h2;
		end
	end
endmodule // rac_far_end
`default_nettype wire

// ===== tb/rac_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "rac_params.svh"
// ----------------------------------------------------------------
// timing checks on the block ports
// ----------------------------------------------------------------
module rac_top_assertions #(
	parameter int CNT_W = 14
)(
	input wire logic MCLK, // clock
	input wire logic RST_B, // reset, low
	input wire logic [`RAC_ADDR_W-1:0] S_AXI_AWADDR, // aw
	input wire logic S_AXI_AWVALID, // aw
	input wire logic S_AXI_AWREADY, // aw
	input wire logic [31:0] S_AXI_WDATA, // w
	input wire logic [3:0] S_AXI_WSTRB, // w
	input wire logic S_AXI_WVALID, // w
	input wire logic S_AXI_WREADY, // w
	input wire logic [1:0] S_AXI_BRESP, // b
	input wire logic S_AXI_BVALID, // b
	input wire logic S_AXI_BREADY, // b
	input wire logic S_AXI_ARVALID, // ar
	input wire logic S_AXI_ARREADY, // ar
	input wire logic S_AXI_RVALID, // r
	input wire logic DATA_HOLD_GO, // go
	input wire logic START_HOLD_GO, // go
	input wire logic STOP_HOLD_GO, // go
	input wire logic [6:0] OWN_ADDR, // address
	input wire logic [CNT_W-1:0] SCL_DIVIDER, // divider
	input wire logic [CNT_W-1:0] SDA_HOLD_CNT, // hold
	input wire logic [CNT_W-1:0] START_HOLD_CNT, // hold
	input wire logic [CNT_W-1:0] STOP_HOLD_CNT, // hold
	input wire logic BIT_TICK, // tick
	input wire logic HOLD_BUSY, // busy
	input wire logic HOLD_DONE // done
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	logic [CNT_W-1:0] hcnt, hexp, tcnt;
	logic tvalid;
	logic go;
	assign go = DATA_HOLD_GO | START_HOLD_GO | STOP_HOLD_GO;
	// hold length and tick gap; a write may restart the tick, so the gap is void then
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			hcnt <= '0;
			hexp <= '0;
			tcnt <= '0;
			tvalid <= 1'b0;
		end
		else
		begin
			if (go)
			begin
				hcnt <= '0;
				hexp <= START_HOLD_GO ? START_HOLD_CNT : STOP_HOLD_GO ? STOP_HOLD_CNT : SDA_HOLD_CNT;
			end
			else if (HOLD_BUSY)
				hcnt <= hcnt + 1'b1;
			if ($rose(S_AXI_BVALID) || BIT_TICK)
				tcnt <= '0;
			else
				tcnt <= tcnt + 1'b1;
			if ($rose(S_AXI_BVALID))
				tvalid <= 1'b0;
			else if (BIT_TICK)
				tvalid <= 1'b1;
		end
	end
	property p_own_addr;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_WSTRB[0]
			&& S_AXI_AWADDR == `RAC_OWN_ADDR_OFS |-> ##2 OWN_ADDR == $past(S_AXI_WDATA[7:1], 2);
	endproperty
	a_own_addr: assert property (p_own_addr) else $error("own address not stored");
	property p_write_resp;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response late");
	property p_resp_stable;
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
	endproperty
	a_resp_stable: assert property (p_resp_stable) else $error("write response dropped");
	property p_read_resp;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
	endproperty
	a_read_resp: assert property (p_read_resp) else $error("read answer late");
	property p_busy_start;
		go |=> HOLD_BUSY;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("hold not started");
	property p_hold_len;
		HOLD_DONE |-> hcnt == hexp && !HOLD_BUSY;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
	property p_done_pulse;
		HOLD_DONE |=> !HOLD_DONE;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
	property p_tick_gap;
		BIT_TICK && tvalid |-> tcnt == SCL_DIVIDER - 1'b1;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("bit period wrong");
	c_hold: cover property (HOLD_DONE);
	c_read: cover property (S_AXI_RVALID);
	c_tick: cover property (BIT_TICK && tvalid);
endmodule // rac_top_assertions
bind rac_top rac_top_assertions #(.CNT_W(CNT_W)) rac_top_assertions_inst (
	.MCLK(MCLK), .RST_B(RST_B), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .DATA_HOLD_GO(DATA_HOLD_GO),
	.START_HOLD_GO(START_HOLD_GO), .STOP_HOLD_GO(STOP_HOLD_GO), .OWN_ADDR(OWN_ADDR),
	.SCL_DIVIDER(SCL_DIVIDER), .SDA_HOLD_CNT(SDA_HOLD_CNT), .START_HOLD_CNT(START_HOLD_CNT),
	.STOP_HOLD_CNT(STOP_HOLD_CNT), .BIT_TICK(BIT_TICK), .HOLD_BUSY(HOLD_BUSY),
	.HOLD_DONE(HOLD_DONE)
);
`default_nettype wire

// ===== tb/rac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rac_params.svh"
// ----------------------------------------------------------------
// bench: rate table rows, then register and reset cases
// ----------------------------------------------------------------
module rac_top_tb;
	typedef struct packed {
		logic [7:0] rate;
		logic [13:0] dv;
		logic [13:0] sd;
		logic [13:0] st;
		logic [13:0] sp;
	} rac_row_t;
	logic mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, fire;
	logic awready, wready, bvalid, arready, rvalid, data_go, start_go, stop_go;
	logic bit_tick, hold_busy, hold_done;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, kind, r;
	logic [6:0] own_addr;
	logic [13:0] scl_divider, sda_hold_cnt, start_hold_cnt, stop_hold_cnt;
	int errors, checks_done, cycles;
	// rate value, then divider and the three holds it must give
	rac_row_t rows [8] = '{
		'{8'h00, 14'h0014, 14'h0007, 14'h0006, 14'h000B},
		'{8'h40, 14'h0028, 14'h000E, 14'h000C, 14'h0016},
		'{8'h80, 14'h0050, 14'h001C, 14'h0018, 14'h002C},
		'{8'h3F, 14'h0F00, 14'h0201, 14'h077E, 14'h0781},
		'{8'hBF, 14'h3C00, 14'h0804, 14'h1DF8, 14'h1E04},
		'{8'h5F, 14'h01E0, 14'h0042, 14'h00EC, 14'h00F2},
		'{8'hD4, 14'h0050, 14'h0011, 14'h0022, 14'h0029},
		'{8'h20, 14'h00A0, 14'h0011, 14'h004E, 14'h0051}
	};
	rac_top #(.CNT_W(14)) rac_top_inst (
		.MCLK(mclk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.DATA_HOLD_GO(data_go), .START_HOLD_GO(start_go), .STOP_HOLD_GO(stop_go),
		.OWN_ADDR(own_addr), .SCL_DIVIDER(scl_divider), .SDA_HOLD_CNT(sda_hold_cnt),
		.START_HOLD_CNT(start_hold_cnt), .STOP_HOLD_CNT(stop_hold_cnt), .BIT_TICK(bit_tick),
		.HOLD_BUSY(hold_busy), .HOLD_DONE(hold_done)
	);
	rac_far_end rac_far_end_inst (.clk(mclk), .rst_b(rst_b), .fire(fire), .kind(kind),
		.data_go(data_go), .start_go(start_go), .stop_go(stop_go));
	// clock and hang guard
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			errors++;
			complete_run();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// bus cycles; one idle edge after each keeps strobes from double assignment
	task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
		output logic [1:0] resp);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge mclk);
	endtask
	// busy edges counted until done must equal the scaled hold
	task automatic run_hold(input logic [1:0] k, input logic [13:0] exp);
		int n;
		n = 0;
		fire <= 1'b1;
		kind <= k;
		@(posedge mclk);
		fire <= 1'b0;
		do
		begin
			@(posedge mclk);
			if (hold_busy)
				n++;
		end
		while (!hold_done);
		check(32'(n), 32'(exp));
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready, fire, kind} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		{errors, checks_done, cycles} = '0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		check(32'(own_addr), 32'h0000_0000);
		axi_read(`RAC_RATE_OFS, d, r);
		check(d, 32'h0000_0000);
		foreach (rows[i])
		begin
			axi_write(`RAC_RATE_OFS, 32'(rows[i].rate), 4'hF, r);
			repeat (2) @(posedge mclk);
			check(32'(scl_divider), 32'(rows[i].dv));
			check(32'(sda_hold_cnt), 32'(rows[i].sd));
			check(32'(start_hold_cnt), 32'(rows[i].st));
			check(32'(stop_hold_cnt), 32'(rows[i].sp));
			axi_read(`RAC_RATE_OFS, d, r);
			check(d, 32'(rows[i].rate));
			axi_read(`RAC_SCLDIV_OFS, d, r);
			check(d, 32'(rows[i].dv));
			run_hold(2'(i % 3), i % 3 == 0 ? rows[i].sd : i % 3 == 1 ? rows[i].st : rows[i].sp);
			repeat (100) @(posedge mclk);
		end
		// own address, bit 0 reads zero, strobe off stores nothing
		axi_write(`RAC_OWN_ADDR_OFS, 32'h0000_00A5, 4'hF, r);
		check(32'(r), 32'(`RAC_RESP_OKAY));
		check(32'(own_addr), 32'h0000_0052);
		axi_read(`RAC_OWN_ADDR_OFS, d, r);
		check(32'(r), 32'(`RAC_RESP_OKAY));
		check(d, 32'h0000_00A4);
		axi_write(`RAC_OWN_ADDR_OFS, 32'h0000_0010, 4'h0, r);
		check(32'(own_addr), 32'h0000_0052);
		// read-only and unmapped places refuse
		axi_write(`RAC_SCLDIV_OFS, 32'h0000_0000, 4'hF, r);
		check(32'(r), 32'(`RAC_RESP_SLVERR));
		check(32'(scl_divider), 32'h0000_00A0);
		axi_read(4'hC, d, r);
		check(32'(r), 32'(`RAC_RESP_SLVERR));
		check(d, 32'h0000_0000);
		// start cuts a running data hold; one edge of the cut hold is counted too
		fire <= 1'b1;
		kind <= 2'h0;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (3) @(posedge mclk);
		run_hold(2'h1, 14'h004F);
		// second reset in mid-run
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		check(32'(own_addr), 32'h0000_0000);
		check(32'(scl_divider), 32'h0000_0014);
		complete_run();
	end
endmodule // rac_top_tb
`default_nettype wire
